// File: design/tppo_pkg.sv
/*
  Package for the timer pair pulse output block: register map, field
  positions, reset values, mode codes and the carrier structs.
  Assumes one 10 MHz clock and prescaled tick enables made elsewhere.
*/
// Contract
// - Pulse mode makes square wave, programmable frequency, duty and polarity.
// - Upper timer is not independently usable while pulse mode runs.
// - Pulse mode output appears on timer pin shared with port bit.
// - Pulse mode flip-flop toggles when lower counter equals either compare; code leaves it unchanged when both match in one tick.
// - Pulse mode double buffer loads lower compare on upper compare match.
// - Width mode exists only on lower timer, resolution up to 8 bits.
// - Width mode drives shared pin; upper timer stays independent 8-bit timer.
// - Width mode toggles on lower compare match and on 2^n overflow; code leaves it unchanged when both fall in one tick.
// - Width mode lower counter clears at the selected 2^n overflow.
// - Width mode double buffer loads lower compare on 2^n overflow.
// - Mode code 10 selects pulse mode; upper clock and source ignored.
// - Mode code 11 selects width mode; cycle codes 01/10/11 give 2^6/2^7/2^8.
package tppo_pkg;

  localparam int ADDR_W = 4;
  localparam int DATA_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [ADDR_W-1:0] REG_RUN = 4'h0;
  localparam logic [ADDR_W-1:0] REG_MODE = 4'h1;
  localparam logic [ADDR_W-1:0] REG_FFCTL = 4'h2;
  localparam logic [ADDR_W-1:0] REG_LOWER_CMP = 4'h3;
  localparam logic [ADDR_W-1:0] REG_UPPER_CMP = 4'h4;
  localparam logic [ADDR_W-1:0] REG_STATUS = 4'h5;
  localparam logic [ADDR_W-1:0] REG_COUNT = 4'h6;

  // ----------------------------------------------------------------
  // Field positions
  // ----------------------------------------------------------------
  localparam int RUN_LOWER_BIT = 0;
  localparam int RUN_UPPER_BIT = 1;
  localparam int MODE_SEL_LSB = 6;
  localparam int CYC_SEL_LSB = 4;
  localparam int UCLK_SEL_LSB = 2;
  localparam int LCLK_SEL_LSB = 0;
  localparam int FF_DBUF_BIT = 0;
  localparam int FF_INV_EN_BIT = 1;
  localparam int FF_INV_SRC_BIT = 2;
  localparam int FF_PIN_SEL_BIT = 3;
  localparam int FF_LOAD_BIT = 4;
  localparam int FF_LOAD_VAL_BIT = 5;
  localparam int STAT_FF_BIT = 0;
  localparam int STAT_UMATCH_BIT = 1;

  // ----------------------------------------------------------------
  // Reset values
  // ----------------------------------------------------------------
  localparam logic [DATA_W-1:0] RUN_RST = 8'h00;
  localparam logic [DATA_W-1:0] MODE_RST = 8'h00;
  localparam logic [3:0] FFCTL_RST = 4'h0;
  localparam logic [DATA_W-1:0] CMP_RST = 8'h00;

  // ----------------------------------------------------------------
  // Codes
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    TPPO_MODE_8BIT = 2'b00,
    TPPO_MODE_16BIT = 2'b01,
    TPPO_MODE_PPG = 2'b10,
    TPPO_MODE_PWM = 2'b11
  } tppo_mode_type;

  localparam logic [1:0] CYC_2P6 = 2'b01;
  localparam logic [1:0] CYC_2P7 = 2'b10;
  localparam logic [1:0] CYC_2P8 = 2'b11;
  localparam logic [DATA_W-1:0] TOP_2P6 = 8'h3f;
  localparam logic [DATA_W-1:0] TOP_2P7 = 8'h7f;
  localparam logic [DATA_W-1:0] TOP_2P8 = 8'hff;

  localparam logic [1:0] LCLK_EXT = 2'b00;
  localparam logic [1:0] LCLK_T1 = 2'b01;
  localparam logic [1:0] LCLK_T4 = 2'b10;
  localparam logic [1:0] LCLK_T16 = 2'b11;
  localparam logic [1:0] UCLK_LMATCH = 2'b00;
  localparam logic [1:0] UCLK_T1 = 2'b01;
  localparam logic [1:0] UCLK_T16 = 2'b10;
  localparam logic [1:0] UCLK_T256 = 2'b11;

  // ----------------------------------------------------------------
  // Carriers
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [ADDR_W-1:0] addr;
    logic [DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } tppo_bus_req_type;

  typedef struct packed {
    logic t1;
    logic t4;
    logic t16;
    logic t256;
  } tppo_ticks_type;

endpackage

// File: design/tppo_timer_pair.sv
/*
  Lower/upper 8-bit timer pair with programmable pulse and pulse-width
  output on one flip-flop, plus a plain register port.
  Assumes tick enables are one-cycle pulses on clk and that the
  external count pin is asynchronous.
*/
`timescale 1ns/1ps
module tppo_timer_pair
  import tppo_pkg::*;
(
  input wire logic clk,
  input wire logic resetn,
  input wire tppo_bus_req_type bus_req,
  output logic [DATA_W-1:0] rdata,
  input wire tppo_ticks_type ticks,
  input wire logic ext_count_pin,
  input wire logic shared_port_bit,
  output logic timer_output_pin,
  output logic output_flip_flop,
  output logic upper_match
);

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  logic [DATA_W-1:0] timer_pair_run_reg;
  logic [DATA_W-1:0] timer_pair_mode_reg;
  logic [3:0] flip_flop_control_reg;
  logic [DATA_W-1:0] lower_compare_reg;
  logic [DATA_W-1:0] lower_compare_buf;
  logic [DATA_W-1:0] upper_compare_reg;
  logic [DATA_W-1:0] lower_up_counter;
  logic [DATA_W-1:0] upper_up_counter;
  logic [2:0] ext_sync;

  tppo_mode_type timer_mode_select;
  logic [1:0] pwm_cycle_select;
  logic [1:0] upper_clock_select;
  logic [1:0] lower_clock_select;
  logic lower_run_bit;
  logic upper_run_bit;
  logic dbuf_en;
  logic invert_en;
  logic pin_sel;
  logic wr_run, wr_mode, wr_ffctl, wr_lower, wr_upper;
  logic ff_load;
  logic mode_ppg, mode_pwm;
  logic ext_edge;
  logic lower_sel_tick;
  logic lower_tick;
  logic [DATA_W-1:0] pwm_top;
  logic lower_match;
  logic period_end;
  logic ff_toggle;
  logic upper_free;
  logic upper_sel_tick;
  logic upper_tick;

  assign timer_mode_select = tppo_mode_type'(timer_pair_mode_reg[MODE_SEL_LSB +: 2]);
  assign pwm_cycle_select = timer_pair_mode_reg[CYC_SEL_LSB +: 2];
  assign upper_clock_select = timer_pair_mode_reg[UCLK_SEL_LSB +: 2];
  assign lower_clock_select = timer_pair_mode_reg[LCLK_SEL_LSB +: 2];
  assign lower_run_bit = timer_pair_run_reg[RUN_LOWER_BIT];
  assign upper_run_bit = timer_pair_run_reg[RUN_UPPER_BIT];
  assign dbuf_en = flip_flop_control_reg[FF_DBUF_BIT];
  assign invert_en = flip_flop_control_reg[FF_INV_EN_BIT];
  assign pin_sel = flip_flop_control_reg[FF_PIN_SEL_BIT];

  assign wr_run = bus_req.wr && (bus_req.addr == REG_RUN);
  assign wr_mode = bus_req.wr && (bus_req.addr == REG_MODE);
  assign wr_ffctl = bus_req.wr && (bus_req.addr == REG_FFCTL);
  assign wr_lower = bus_req.wr && (bus_req.addr == REG_LOWER_CMP);
  assign wr_upper = bus_req.wr && (bus_req.addr == REG_UPPER_CMP);
  assign ff_load = wr_ffctl && bus_req.wdata[FF_LOAD_BIT];

  // ----------------------------------------------------------------
  // Mode decode and count enable
  // ----------------------------------------------------------------
  // Upper clock select and invert source are not consulted here
  assign mode_ppg = (timer_mode_select == TPPO_MODE_PPG);
  assign mode_pwm = (timer_mode_select == TPPO_MODE_PWM);

  // Edge taken from the second and third stages only
  assign ext_edge = ext_sync[1] && !ext_sync[2];

  always_comb begin
    unique case (lower_clock_select)
      LCLK_EXT: lower_sel_tick = ext_edge;
      LCLK_T1: lower_sel_tick = ticks.t1;
      LCLK_T4: lower_sel_tick = ticks.t4;
      LCLK_T16: lower_sel_tick = ticks.t16;
    endcase
  end

  // Upper run bit is deliberately ignored for the pulse channel
  assign lower_tick = lower_run_bit && (mode_ppg || mode_pwm) && lower_sel_tick;

  // Code 00 has no documented period; it falls back to the 8-bit wrap
  always_comb begin
    unique case (pwm_cycle_select)
      CYC_2P6: pwm_top = TOP_2P6;
      CYC_2P7: pwm_top = TOP_2P7;
      CYC_2P8: pwm_top = TOP_2P8;
      default: pwm_top = TOP_2P8;
    endcase
  end

  assign lower_match = lower_tick && (lower_up_counter == lower_compare_reg);
  assign period_end = lower_tick && ((mode_ppg && (lower_up_counter == upper_compare_reg))
                      || (mode_pwm && (lower_up_counter == pwm_top)));
  // Xor so a coincident pair of events cancels instead of double-counting
  assign ff_toggle = invert_en && (lower_match ^ period_end);

  // ----------------------------------------------------------------
  // Register writes
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_pair_run_reg <= RUN_RST;
    end else if (wr_run) begin
      timer_pair_run_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_pair_mode_reg <= MODE_RST;
    end else if (wr_mode) begin
      timer_pair_mode_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      flip_flop_control_reg <= FFCTL_RST;
    end else if (wr_ffctl) begin
      flip_flop_control_reg <= bus_req.wdata[3:0];
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_compare_reg <= CMP_RST;
    end else if (wr_upper) begin
      upper_compare_reg <= bus_req.wdata;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_compare_buf <= CMP_RST;
    end else if (wr_lower) begin
      lower_compare_buf <= bus_req.wdata;
    end
  end

  // Buffered writes land only at a period boundary, so duty never glitches
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_compare_reg <= CMP_RST;
    end else if (wr_lower && !dbuf_en) begin
      lower_compare_reg <= bus_req.wdata;
    end else if (period_end && dbuf_en) begin
      lower_compare_reg <= lower_compare_buf;
    end
  end

  // ----------------------------------------------------------------
  // Lower counter and output flip-flop
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      ext_sync <= 3'h0;
    end else begin
      ext_sync <= {ext_sync[1:0], ext_count_pin};
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      lower_up_counter <= 8'h00;
    end else if (!lower_run_bit) begin
      lower_up_counter <= 8'h00;
    end else if (period_end) begin
      lower_up_counter <= 8'h00;
    end else if (lower_tick) begin
      lower_up_counter <= lower_up_counter + 8'h01;
    end
  end

  // Preloading the level picks active-high or active-low pulses
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      output_flip_flop <= 1'b0;
    end else if (ff_load) begin
      output_flip_flop <= bus_req.wdata[FF_LOAD_VAL_BIT];
    end else if (ff_toggle) begin
      output_flip_flop <= !output_flip_flop;
    end
  end

  // Registered so the pin never carries a mux glitch
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      timer_output_pin <= 1'b0;
    end else if (pin_sel) begin
      timer_output_pin <= output_flip_flop;
    end else begin
      timer_output_pin <= shared_port_bit;
    end
  end

  // ----------------------------------------------------------------
  // Upper interval timer
  // ----------------------------------------------------------------
  assign upper_free = (timer_mode_select == TPPO_MODE_8BIT) || mode_pwm;

  always_comb begin
    unique case (upper_clock_select)
      UCLK_LMATCH: upper_sel_tick = lower_match;
      UCLK_T1: upper_sel_tick = ticks.t1;
      UCLK_T16: upper_sel_tick = ticks.t16;
      UCLK_T256: upper_sel_tick = ticks.t256;
    endcase
  end

  assign upper_tick = upper_run_bit && upper_free && upper_sel_tick;

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_up_counter <= 8'h00;
    end else if (!upper_run_bit || !upper_free) begin
      upper_up_counter <= 8'h00;
    end else if (upper_tick && (upper_up_counter == upper_compare_reg)) begin
      upper_up_counter <= 8'h00;
    end else if (upper_tick) begin
      upper_up_counter <= upper_up_counter + 8'h01;
    end
  end

  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      upper_match <= 1'b0;
    end else begin
      upper_match <= upper_tick && (upper_up_counter == upper_compare_reg);
    end
  end

  // ----------------------------------------------------------------
  // Read port
  // ----------------------------------------------------------------
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      rdata <= 8'h00;
    end else if (bus_req.rd) begin
      unique case (bus_req.addr)
        REG_RUN: rdata <= timer_pair_run_reg;
        REG_MODE: rdata <= timer_pair_mode_reg;
        REG_FFCTL: rdata <= {4'h0, flip_flop_control_reg};
        REG_LOWER_CMP: rdata <= lower_compare_reg;
        REG_UPPER_CMP: rdata <= upper_compare_reg;
        REG_STATUS: rdata <= {6'h00, upper_match, output_flip_flop};
        REG_COUNT: rdata <= lower_up_counter;
        default: rdata <= 8'h00;
      endcase
    end else begin
      rdata <= 8'h00;
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  chk_ppg_period_restart: assert property (@(posedge clk) disable iff (!resetn)
    mode_ppg && lower_tick && (lower_up_counter == upper_compare_reg) && lower_run_bit
    |=> lower_up_counter == 8'h00)
    else $error("pulse counter did not restart after upper match");

  chk_pwm_overflow_clear: assert property (@(posedge clk) disable iff (!resetn)
    mode_pwm && lower_tick && (pwm_cycle_select == CYC_2P6) && (lower_up_counter == TOP_2P6)
    |=> lower_up_counter == 8'h00)
    else $error("width counter did not clear at 2^6 overflow");

  chk_match_toggles_ff: assert property (@(posedge clk) disable iff (!resetn)
    invert_en && !ff_load && (lower_match != period_end)
    |=> output_flip_flop != $past(output_flip_flop))
    else $error("flip-flop missed a toggle on a match");

  chk_ff_holds_idle: assert property (@(posedge clk) disable iff (!resetn)
    !ff_load && !ff_toggle |=> $stable(output_flip_flop))
    else $error("flip-flop changed without a cause");

  chk_dbuf_period_load: assert property (@(posedge clk) disable iff (!resetn)
    period_end && dbuf_en && !wr_lower
    |=> lower_compare_reg == $past(lower_compare_buf))
    else $error("buffered compare not loaded at period end");

  chk_stop_clears_count: assert property (@(posedge clk) disable iff (!resetn)
    !lower_run_bit |=> lower_up_counter == 8'h00)
    else $error("stopped counter not zero");

  chk_count_advances: assert property (@(posedge clk) disable iff (!resetn)
    lower_tick && !period_end |=> lower_up_counter == $past(lower_up_counter) + 8'h01)
    else $error("counter did not advance on tick");

  chk_upper_idle_ppg: assert property (@(posedge clk) disable iff (!resetn)
    mode_ppg ##1 mode_ppg |-> !upper_match && (upper_up_counter == 8'h00))
    else $error("upper timer active in pulse mode");

  chk_pin_follows_ff: assert property (@(posedge clk) disable iff (!resetn)
    pin_sel |=> timer_output_pin == $past(output_flip_flop))
    else $error("timer pin does not follow flip-flop");

endmodule

// File: verification/tppo_pin_load.sv
/*
  Load on the timer output pin: measures the latest complete high and low
  spans in clocks. Assumes the pin is sampled on the block clock.
*/
`timescale 1ns/1ps
module tppo_pin_load (
  input wire logic clk,
  input wire logic resetn,
  input wire logic pin,
  output logic [15:0] hi_len,
  output logic [15:0] lo_len
);
  logic last;
  logic [15:0] span;

  // ----------------------------------------
  // Span measurement
  // ----------------------------------------
  // A span counts only once it has ended, so a stuck pin never passes
  always_ff @(posedge clk or negedge resetn) begin
    if (!resetn) begin
      last <= 1'b0;
      span <= 16'h0000;
      hi_len <= 16'h0000;
      lo_len <= 16'h0000;
    end else if (pin === last) begin
      span <= span + 16'h0001;
    end else begin
      if (last) begin
        hi_len <= span;
      end else begin
        lo_len <= span;
      end
      last <= pin;
      span <= 16'h0001;
    end
  end
endmodule

// File: verification/test_tppo_timer_pair.sv
/*
  Self-checking bench for the timer pair pulse output block.
  Assumes the register map and codes of tppo_pkg; ticks come from the bench.
*/
`timescale 1ns/1ps
module test_tppo_timer_pair;
  import tppo_pkg::*;
  logic clk;
  logic resetn;
  tppo_bus_req_type bus_req;
  logic [DATA_W-1:0] rdata;
  tppo_ticks_type ticks;
  logic ext_count_pin;
  logic shared_port_bit;
  logic timer_output_pin;
  logic output_flip_flop;
  logic upper_match;
  logic [15:0] hi_len;
  logic [15:0] lo_len;
  logic [15:0] rnd;
  logic [15:0] n_ticks;
  logic [15:0] um_cnt;
  logic sp_seen;
  logic [1:0] tick_mode;
  logic [7:0] up;
  logic [7:0] lo;
  int n_errors;
  int comparisons;

  tppo_timer_pair u_tppo_timer_pair (.clk(clk), .resetn(resetn), .bus_req(bus_req),
    .rdata(rdata), .ticks(ticks), .ext_count_pin(ext_count_pin),
    .shared_port_bit(shared_port_bit), .timer_output_pin(timer_output_pin),
    .output_flip_flop(output_flip_flop), .upper_match(upper_match));
  tppo_pin_load u_tppo_pin_load (.clk(clk), .resetn(resetn), .pin(timer_output_pin),
    .hi_len(hi_len), .lo_len(lo_len));

  function automatic logic [15:0] lfsr_next(input logic [15:0] s);
    return s[0] ? ((s >> 1) ^ 16'hb400) : (s >> 1);
  endfunction

  // ----------------------------------------
  // Clock, stimulus sources
  // ----------------------------------------
  initial begin
    clk = 1'b0;
    forever #50 clk = ~clk;
  end

  // Tick mode: 0 stopped, 1 every clock, 2 random on t1 and on the slow tick; tally held while stopped
  always @(posedge clk) begin
    rnd <= lfsr_next(rnd);
    sp_seen <= shared_port_bit;
    ticks <= '{t1: (tick_mode == 2'd2) ? rnd[0] : tick_mode[0], t4: rnd[3],
      t16: (tick_mode == 2'd2) ? rnd[5] : 1'b0, t256: rnd[7]};
    ext_count_pin <= rnd[9];
    shared_port_bit <= rnd[11];
    um_cnt <= um_cnt + {15'h0000, upper_match};
    if (tick_mode == 2'd2) begin
      n_ticks <= n_ticks + {15'h0000, rnd[5]};
    end else if (tick_mode == 2'd1) begin
      n_ticks <= 16'h0000;
    end
  end

  // ----------------------------------------
  // Bus and compare tasks
  // ----------------------------------------
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: d, wr: 1'b1, rd: 1'b0};
    @(posedge clk);
    bus_req <= '0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [7:0] d);
    @(posedge clk);
    bus_req <= '{addr: a, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
    @(posedge clk);
    bus_req <= '0;
    #1;
    d = rdata;
  endtask

  task automatic check(input logic [15:0] got, input logic [15:0] exp);
    comparisons++;
    if (got !== exp) begin
      n_errors++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic check_reg(input logic [3:0] a, input logic [15:0] exp);
    logic [7:0] d;
    rd(a, d);
    check({8'h00, d}, exp);
  endtask

  task automatic wait_clk(input int n);
    repeat (n) @(posedge clk);
  endtask

  task automatic complete_run;
    $display("comparisons %0d n_errors %0d", comparisons, n_errors);
    if (n_errors == 0 && comparisons > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  // ----------------------------------------
  // Scenarios
  // ----------------------------------------
  task automatic run_ppg(input logic inv);
    up = 8'h10 + {1'b0, rnd[6:0]};
    lo = 8'h01 + (rnd[15:8] % (up - 8'h01));
    tick_mode <= 2'd0;
    wr(REG_RUN, 8'h00);
    wr(REG_MODE, {TPPO_MODE_PPG, rnd[5:2], LCLK_T1});
    wr(REG_LOWER_CMP, lo);
    wr(REG_UPPER_CMP, up);
    wr(REG_FFCTL, {2'b00, inv, 2'b11, rnd[2], 2'b10});
    wr(REG_RUN, 8'h03);
    tick_mode <= 2'd1;
    wait_clk(3 * up + 10);
    check(hi_len, inv ? {8'h00, lo} + 16'h1 : {8'h00, up - lo});
    check(lo_len, inv ? {8'h00, up - lo} : {8'h00, lo} + 16'h1);
    $display("pulse mode test done, polarity %0d", inv);
  endtask

  // Stop ticks so the buffered value cannot move before it is read back
  task automatic run_dbuf(input logic [7:0] old_v, input int span);
    logic [7:0] nv;
    nv = (old_v == 8'h01) ? 8'h02 : 8'h01;
    tick_mode <= 2'd0;
    wr(REG_FFCTL, 8'h1b);
    wr(REG_LOWER_CMP, nv);
    check_reg(REG_LOWER_CMP, {8'h00, old_v});
    check({15'h0000, output_flip_flop}, 16'h0000);
    check_reg(REG_STATUS, 16'h0000);
    tick_mode <= 2'd1;
    wait_clk(span + 3);
    check_reg(REG_LOWER_CMP, {8'h00, nv});
    $display("double buffer test done");
  endtask

  task automatic run_pwm(input logic [1:0] cyc);
    logic [7:0] top;
    logic [15:0] um0;
    top = (cyc == CYC_2P6) ? TOP_2P6 : (cyc == CYC_2P7) ? TOP_2P7 : TOP_2P8;
    lo = 8'h01 + (rnd[15:8] % (top - 8'h01));
    tick_mode <= 2'd0;
    wr(REG_RUN, 8'h00);
    wr(REG_MODE, {TPPO_MODE_PWM, cyc, UCLK_T1, LCLK_T1});
    wr(REG_UPPER_CMP, 8'h0a);
    // Double buffer off first, else the compare write only reaches the buffer
    wr(REG_FFCTL, 8'h1a);
    wr(REG_LOWER_CMP, lo);
    wr(REG_RUN, 8'h03);
    um0 = um_cnt;
    tick_mode <= 2'd1;
    wait_clk(3 * top + 10);
    check(hi_len, {8'h00, top - lo});
    check(lo_len, {8'h00, lo} + 16'h1);
    check({15'h0000, um_cnt != um0}, 16'h0001);
    run_dbuf(lo, top);
    $display("width mode test done, cycle code %0d", cyc);
  endtask

  initial begin
    #(100 * 30000);
    n_errors++;
    complete_run();
  end

  initial begin
    resetn = 1'b0;
    bus_req = '0;
    ticks = '0;
    ext_count_pin = 1'b0;
    shared_port_bit = 1'b0;
    rnd = 16'hb805;
    n_ticks = 16'h0000;
    um_cnt = 16'h0000;
    tick_mode = 2'd0;
    n_errors = 0;
    comparisons = 0;
    wait_clk(3);
    resetn <= 1'b1;
    check_reg(REG_MODE, {8'h00, MODE_RST});
    check_reg(REG_FFCTL, {12'h000, FFCTL_RST});
    check_reg(4'hf, 16'h0000);
    wr(REG_FFCTL, 8'h00);
    repeat (8) begin
      @(posedge clk);
      #1;
      check({15'h0000, timer_output_pin}, {15'h0000, sp_seen});
    end
    $display("reset and pin sharing test done");
    run_ppg(1'b0);
    run_ppg(1'b1);
    run_dbuf(lo, up);
    tick_mode <= 2'd0;
    wr(REG_MODE, {TPPO_MODE_PPG, 4'h0, LCLK_T16});
    wr(REG_RUN, 8'h00);
    check_reg(REG_COUNT, 16'h0000);
    wr(REG_RUN, 8'h03);
    tick_mode <= 2'd2;
    wait_clk(300);
    tick_mode <= 2'd0;
    wait_clk(2);
    check_reg(REG_COUNT, n_ticks % ({8'h00, up} + 16'h1));
    $display("random tick count test done");
    // Interval mode must leave the lower counter parked
    wr(REG_MODE, {TPPO_MODE_8BIT, 2'b00, UCLK_T1, LCLK_T1});
    wr(REG_RUN, 8'h00);
    wr(REG_RUN, 8'h03);
    tick_mode <= 2'd1;
    wait_clk(20);
    check_reg(REG_COUNT, 16'h0000);
    $display("interval mode hold test done");
    for (int i = 1; i < 4; i++) begin
      run_pwm(i[1:0]);
    end
    complete_run();
  end
endmodule
